//--- hdl/module_access_error_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "mae_consts.svh"

module module_access_error_monitor
  import mae_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter logic [`MAE_NUM_SRC-1:0] ASYNC_SOURCES = 5'h18
) (
  input wire logic mclk,
  input wire logic resetn,
  // register bus
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // network core register access observation
  input wire logic netc_req,
  input wire logic netc_write,
  input wire logic [1:0] netc_size,
  input wire logic [1:0] netc_min_size,
  input wire logic netc_read_only,
  input wire logic netc_mapped,
  output logic netc_resp_err,
  // peripheral interface access observation
  input wire logic perif_req,
  input wire logic perif_write,
  input wire logic perif_mapped,
  output logic perif_resp_err,
  // external module error lines
  input wire logic ifilt_err,
  input wire logic hostif_err,
  // processor side
  output logic bus_abort,
  output logic module_access_irq
);

  localparam int NSRC = `MAE_NUM_SRC;

  initial begin
    if (ADDR_W < 4) $error("address width too small for the register map");
    if (ASYNC_SOURCES[`MAE_SRC_SCB:`MAE_SRC_NETC] != 3'h0)
      $error("internally detected sources are synchronous");
  end

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] ofs;
    ofs = 8'(a);
    is_mapped = (ofs == `MAE_COLLECTOR_OFS) || (ofs == `MAE_IRQ_STATUS_OFS) ||
      (ofs == `MAE_IRQ_MASK_OFS);
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // network core access checks

  logic netc_unassigned;
  logic netc_narrow_byte;
  logic netc_narrow_half;
  logic netc_ro_write;
  logic netc_err;

  assign netc_unassigned = netc_req & ~netc_mapped;
  assign netc_narrow_byte = netc_req & netc_mapped & netc_write &
    (netc_size == `MAE_SIZE_BYTE) & (netc_min_size != `MAE_SIZE_BYTE);
  assign netc_narrow_half = netc_req & netc_mapped & netc_write &
    (netc_size == `MAE_SIZE_HALF) & (netc_min_size == `MAE_SIZE_WORD);
  assign netc_ro_write = netc_req & netc_mapped & netc_write & netc_read_only;

  always_ff @(posedge mclk) begin
    if (!resetn) netc_err <= 1'b0;
    else netc_err <= netc_unassigned | netc_narrow_byte | netc_narrow_half | netc_ro_write;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) netc_resp_err <= 1'b0;
    else netc_resp_err <= netc_unassigned & ~netc_write;
  end

  ////////////////////////////////////////////////////////////////////////////
  // peripheral interface access checks

  logic perif_err;

  always_ff @(posedge mclk) begin
    if (!resetn) perif_err <= 1'b0;
    else perif_err <= perif_req & ~perif_mapped;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) perif_resp_err <= 1'b0;
    else perif_resp_err <= perif_req & ~perif_mapped & ~perif_write;
  end

  // error answer on the system bus aborts the issuing core
  always_ff @(posedge mclk) begin
    if (!resetn) bus_abort <= 1'b0;
    else bus_abort <= (netc_unassigned & ~netc_write) |
      (perif_req & ~perif_mapped & ~perif_write);
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus slave

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wr_state_t wr_state;
  logic do_write;
  logic do_read;
  logic wr_hit;
  logic scb_err;
  logic [NSRC-1:0] collector;
  logic [NSRC-1:0] irq_status;
  logic [NSRC-1:0] irq_mask;
  logic [NSRC-1:0] new_entry;
  logic collector_clear;

  assign awready = ~aw_held & (wr_state == WR_IDLE);
  assign wready = ~w_held & (wr_state == WR_IDLE);
  assign do_write = aw_held & w_held & (wr_state == WR_IDLE);
  assign wr_hit = is_mapped(aw_addr);
  assign arready = ~rvalid;
  assign do_read = arvalid & arready;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (awvalid & awready) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wvalid & wready) begin
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_state <= WR_IDLE;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      case (wr_state)
        WR_IDLE: begin
          if (do_write) begin
            wr_state <= WR_RESP;
            bvalid <= 1'b1;
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (bready) begin
            wr_state <= WR_IDLE;
            bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state <= WR_IDLE;
          bvalid <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (do_read) begin
      rvalid <= 1'b1;
      rresp <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (8'(araddr))
        `MAE_COLLECTOR_OFS: rdata <= {27'h0, collector};
        `MAE_IRQ_STATUS_OFS: rdata <= {27'h0, irq_status};
        `MAE_IRQ_MASK_OFS: rdata <= {27'h0, irq_mask};
        default: rdata <= 32'h0000_0000;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // own unassigned offsets count as control block errors
  always_ff @(posedge mclk) begin
    if (!resetn) scb_err <= 1'b0;
    else scb_err <= (do_write & ~wr_hit) | (do_read & ~is_mapped(araddr));
  end

  // whole-word write of zero clears the collector
  assign collector_clear = do_write & (8'(aw_addr) == `MAE_COLLECTOR_OFS) &
    (w_strb == 4'hf) & (w_data == 32'h0000_0000);

  always_ff @(posedge mclk) begin
    if (!resetn) irq_mask <= `MAE_IRQ_MASK_RST;
    else if (do_write & (8'(aw_addr) == `MAE_IRQ_MASK_OFS) & w_strb[0])
      irq_mask <= w_data[NSRC-1:0];
  end

  // status: write one clears, new entry wins
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq_status <= `MAE_IRQ_STATUS_RST;
    end else begin
      if (do_write & (8'(aw_addr) == `MAE_IRQ_STATUS_OFS) & w_strb[0])
        irq_status <= (irq_status & ~w_data[NSRC-1:0]) | new_entry;
      else
        irq_status <= irq_status | new_entry;
    end
  end

  assign module_access_irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // collector flags

  logic [NSRC-1:0] src_err;

  assign src_err[`MAE_SRC_NETC] = netc_err;
  assign src_err[`MAE_SRC_PERIF] = perif_err;
  assign src_err[`MAE_SRC_SCB] = scb_err;
  assign src_err[`MAE_SRC_IFILT] = ifilt_err;
  assign src_err[`MAE_SRC_HOSTIF] = hostif_err;

  generate
    for (genvar i = 0; i < NSRC; i++) begin : g_src
      error_capture #(
        .ASYNC(ASYNC_SOURCES[i]),
        .STAGES(`MAE_SYNC_STAGES)
      ) u_capture (
        .mclk(mclk),
        .resetn(resetn),
        .err_in(src_err[i]),
        .clear(collector_clear),
        .flag(collector[i]),
        .new_entry(new_entry[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_netc_byte_flag: assert property (@(posedge mclk) disable iff (!resetn)
    netc_narrow_byte |=> ##1 collector[`MAE_SRC_NETC])
    else $error("byte write to wide location not collected");

  chk_netc_half_flag: assert property (@(posedge mclk) disable iff (!resetn)
    netc_narrow_half |-> ##2 collector[`MAE_SRC_NETC])
    else $error("half-word write to word location not collected");

  chk_netc_ro_flag: assert property (@(posedge mclk) disable iff (!resetn)
    netc_ro_write |=> netc_err)
    else $error("read-only write not flagged");

  chk_sync_pulse_caught: assert property (@(posedge mclk) disable iff (!resetn)
    perif_req && !perif_mapped |-> ##2 collector[`MAE_SRC_PERIF])
    else $error("one-cycle peripheral error lost");

  chk_async_two_cycle: assert property (@(posedge mclk) disable iff (!resetn)
    (ASYNC_SOURCES[`MAE_SRC_HOSTIF] && hostif_err) [*2] |-> ##2 collector[`MAE_SRC_HOSTIF])
    else $error("held asynchronous error not collected");

  chk_zero_clears: assert property (@(posedge mclk) disable iff (!resetn)
    collector_clear && (src_err == 5'h00) && (g_src[3].u_capture.level == 1'b0) &&
    (g_src[4].u_capture.level == 1'b0) |=> collector == 5'h00)
    else $error("zero write did not clear collector");

  chk_flag_sticky: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(collector[`MAE_SRC_NETC]) |-> $past(collector_clear))
    else $error("collector flag dropped without clear");

  chk_irq_on_entry: assert property (@(posedge mclk) disable iff (!resetn)
    (|(new_entry & irq_mask)) |=> module_access_irq)
    else $error("recorded error raised no interrupt");

  chk_bus_err_read: assert property (@(posedge mclk) disable iff (!resetn)
    perif_req && !perif_mapped && !perif_write |=> perif_resp_err && bus_abort)
    else $error("unassigned read got no error answer");

  chk_abort_cause: assert property (@(posedge mclk) disable iff (!resetn)
    bus_abort |-> netc_resp_err || perif_resp_err)
    else $error("abort without error answer");

  chk_scb_unmapped: assert property (@(posedge mclk) disable iff (!resetn)
    do_read && !is_mapped(araddr) |=> ##1 collector[`MAE_SRC_SCB])
    else $error("own unassigned read not collected");

  chk_error_active_high: assert property (@(posedge mclk) disable iff (!resetn)
    !netc_err && !$past(collector[`MAE_SRC_NETC]) && !collector[`MAE_SRC_NETC]
      |=> !collector[`MAE_SRC_NETC])
    else $error("flag set with error line low");

endmodule : module_access_error_monitor
`default_nettype wire

//--- hdl/mae_consts.svh
`ifndef MAE_CONSTS_SVH
`define MAE_CONSTS_SVH

// register byte offsets
`define MAE_COLLECTOR_OFS 8'h00
`define MAE_IRQ_STATUS_OFS 8'h04
`define MAE_IRQ_MASK_OFS 8'h08

// reset values
`define MAE_COLLECTOR_RST 5'h00
`define MAE_IRQ_STATUS_RST 5'h00
`define MAE_IRQ_MASK_RST 5'h1f

// source bit positions within collector, status and mask
`define MAE_SRC_NETC 0
`define MAE_SRC_PERIF 1
`define MAE_SRC_SCB 2
`define MAE_SRC_IFILT 3
`define MAE_SRC_HOSTIF 4
`define MAE_NUM_SRC 5

// access sizes
`define MAE_SIZE_BYTE 2'h0
`define MAE_SIZE_HALF 2'h1
`define MAE_SIZE_WORD 2'h2

// timing
`define MAE_MCLK_PERIOD_PS 4000
`define MAE_SYS_PERIOD_PS 8000
`define MAE_ASYNC_MIN_PULSE_PS (2 * `MAE_SYS_PERIOD_PS)
`define MAE_ASYNC_MIN_CYCLES \
  ((`MAE_ASYNC_MIN_PULSE_PS + `MAE_MCLK_PERIOD_PS - 1) / `MAE_MCLK_PERIOD_PS)
`define MAE_SYNC_STAGES 2

`endif

//--- hdl/mae_pkg.sv
package mae_pkg;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;

endpackage : mae_pkg

//--- hdl/error_capture.sv
`timescale 1ns/1ps
`default_nettype none
`include "mae_consts.svh"

module error_capture #(
  parameter bit ASYNC = 1'b0,
  parameter int STAGES = `MAE_SYNC_STAGES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic err_in,
  input wire logic clear,
  output logic flag,
  output logic new_entry
);

  initial begin
    if (STAGES < 2) $error("error_capture needs at least two sync stages");
  end

  logic level;

  generate
    if (ASYNC) begin : g_async
      logic [STAGES-1:0] sync;
      // only the last stage is looked at
      always_ff @(posedge mclk) begin
        if (!resetn) sync <= '0;
        else sync <= {sync[STAGES-2:0], err_in};
      end
      assign level = sync[STAGES-1];
    end else begin : g_sync
      assign level = err_in;
    end
  endgenerate

  assign new_entry = level & ~flag;

  // set beats a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!resetn) flag <= 1'b0;
    else flag <= level | (flag & ~clear);
  end

endmodule : error_capture
`default_nettype wire

//--- test/err_source_model.sv
`timescale 1ns/1ps
`default_nettype none

module err_source_model (
  input wire logic mclk,
  output logic netc_req,
  output logic netc_write,
  output logic [1:0] netc_size,
  output logic [1:0] netc_min_size,
  output logic netc_read_only,
  output logic netc_mapped,
  output logic perif_req,
  output logic perif_write,
  output logic perif_mapped,
  output logic ifilt_err,
  output logic hostif_err
);
  initial begin
    {netc_req, netc_write, netc_size, netc_min_size, netc_read_only, netc_mapped} = '0;
    {perif_req, perif_write, perif_mapped, ifilt_err, hostif_err} = '0;
  end

  // one-cycle access, synchronous to mclk
  task automatic netc_access(input logic wr, input logic [1:0] sz, mn, input logic ro, mp);
    @(posedge mclk);
    netc_req <= 1'b1;
    netc_write <= wr;
    netc_size <= sz;
    netc_min_size <= mn;
    netc_read_only <= ro;
    netc_mapped <= mp;
    @(posedge mclk);
    netc_req <= 1'b0;
  endtask : netc_access

  task automatic perif_access(input logic wr, mp);
    @(posedge mclk);
    perif_req <= 1'b1;
    perif_write <= wr;
    perif_mapped <= mp;
    @(posedge mclk);
    perif_req <= 1'b0;
  endtask : perif_access

  // off-edge pulse of exactly two system periods
  task automatic async_pulse(input logic host);
    @(posedge mclk);
    #1.3;
    if (host) hostif_err <= 1'b1;
    else ifilt_err <= 1'b1;
    #16.0;
    hostif_err <= 1'b0;
    ifilt_err <= 1'b0;
  endtask : async_pulse
endmodule : err_source_model

`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mae_consts.svh"
`define CHK(w, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", w, e, g); end end

module testbench
  import mae_pkg::*;
;
  logic mclk, resetn;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, netc_size, netc_min_size;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic netc_req, netc_write, netc_read_only, netc_mapped, netc_resp_err;
  logic perif_req, perif_write, perif_mapped, perif_resp_err;
  logic ifilt_err, hostif_err, bus_abort, module_access_irq;
  int mismatches = 0;
  int compares = 0;

  module_access_error_monitor dut (.mclk(mclk), .resetn(resetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .netc_req(netc_req), .netc_write(netc_write), .netc_size(netc_size),
    .netc_min_size(netc_min_size), .netc_read_only(netc_read_only),
    .netc_mapped(netc_mapped), .netc_resp_err(netc_resp_err), .perif_req(perif_req),
    .perif_write(perif_write), .perif_mapped(perif_mapped), .perif_resp_err(perif_resp_err),
    .ifilt_err(ifilt_err), .hostif_err(hostif_err), .bus_abort(bus_abort),
    .module_access_irq(module_access_irq));

  err_source_model src (.mclk(mclk), .netc_req(netc_req), .netc_write(netc_write),
    .netc_size(netc_size), .netc_min_size(netc_min_size), .netc_read_only(netc_read_only),
    .netc_mapped(netc_mapped), .perif_req(perif_req), .perif_write(perif_write),
    .perif_mapped(perif_mapped), .ifilt_err(ifilt_err), .hostif_err(hostif_err));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic timed_out(input string w);
    mismatches++;
    $display("CHECK FAILED %s expected handshake seen timeout", w);
    tally_and_finish();
  endtask : timed_out

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    int n;
    bit ta, tw;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ta = 0;
    tw = 0;
    for (n = 0; n < 40 && !(ta && tw); n++) begin
      @(posedge mclk);
      if (!ta && awready === 1'b1) begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (!tw && wready === 1'b1) begin
        tw = 1;
        wvalid <= 1'b0;
      end
    end
    for (n = 0; n < 40 && bvalid !== 1'b1; n++) @(posedge mclk);
    if (n == 40 || !(ta && tw)) timed_out("write");
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (arready === 1'b1) break;
    end
    arvalid <= 1'b0;
    for (n = n; n < 40 && rvalid !== 1'b1; n++) @(posedge mclk);
    if (n == 40) timed_out("read");
    rready <= 1'b0;
    `CHK("rdata", ed, rdata)
    `CHK("rresp", er, rresp)
  endtask : axi_read

  task automatic clear_all;
    axi_write(`MAE_COLLECTOR_OFS, 32'h0, 4'hf, RESP_OKAY);
    axi_write(`MAE_IRQ_STATUS_OFS, 32'h1f, 4'hf, RESP_OKAY);
  endtask : clear_all

  ////////////////////////////////////////////////////////////////////////////////
  task automatic netc_case(input logic wr, input logic [1:0] sz, mn, input logic ro, mp, e);
    src.netc_access(wr, sz, mn, ro, mp);
    #1;
    `CHK("netc_resp_err", !wr && !mp, netc_resp_err)
    `CHK("bus_abort", !wr && !mp, bus_abort)
    step(3);
    axi_read(`MAE_COLLECTOR_OFS, {31'h0, e}, RESP_OKAY);
    clear_all();
  endtask : netc_case

  task automatic t_reset;
    `CHK("irq", 1'b0, module_access_irq)
    axi_read(`MAE_COLLECTOR_OFS, 32'h0, RESP_OKAY);
    axi_read(`MAE_IRQ_STATUS_OFS, 32'h0, RESP_OKAY);
    axi_read(`MAE_IRQ_MASK_OFS, 32'h1f, RESP_OKAY);
  endtask : t_reset

  task automatic t_netc;
    netc_case(1'b1, `MAE_SIZE_BYTE, `MAE_SIZE_HALF, 1'b0, 1'b1, 1'b1);
    netc_case(1'b1, `MAE_SIZE_BYTE, `MAE_SIZE_WORD, 1'b0, 1'b1, 1'b1);
    netc_case(1'b1, `MAE_SIZE_HALF, `MAE_SIZE_WORD, 1'b0, 1'b1, 1'b1);
    netc_case(1'b1, `MAE_SIZE_HALF, `MAE_SIZE_HALF, 1'b0, 1'b1, 1'b0);
    netc_case(1'b1, `MAE_SIZE_WORD, `MAE_SIZE_BYTE, 1'b1, 1'b1, 1'b1);
    netc_case(1'b0, `MAE_SIZE_WORD, `MAE_SIZE_BYTE, 1'b1, 1'b1, 1'b0);
    netc_case(1'b0, `MAE_SIZE_WORD, `MAE_SIZE_BYTE, 1'b0, 1'b0, 1'b1);
  endtask : t_netc

  task automatic t_perif;
    src.perif_access(1'b0, 1'b0);
    #1;
    `CHK("perif_resp_err", 1'b1, perif_resp_err)
    `CHK("bus_abort", 1'b1, bus_abort)
    step(1);
    `CHK("perif_resp_err pulse", 1'b0, perif_resp_err)
    `CHK("irq", 1'b1, module_access_irq)
    axi_read(`MAE_COLLECTOR_OFS, 32'h2, RESP_OKAY);
    src.perif_access(1'b0, 1'b1);
    #1;
    `CHK("mapped abort", 1'b0, bus_abort)
    axi_write(`MAE_COLLECTOR_OFS, 32'h0, 4'hf, RESP_OKAY);
    axi_read(`MAE_COLLECTOR_OFS, 32'h0, RESP_OKAY);
    axi_write(`MAE_IRQ_STATUS_OFS, 32'h2, 4'hf, RESP_OKAY);
  endtask : t_perif

  task automatic t_scb;
    axi_read(8'h10, 32'h0, RESP_SLVERR);
    axi_write(8'h14, 32'h1, 4'hf, RESP_SLVERR);
    step(3);
    axi_read(`MAE_COLLECTOR_OFS, 32'h4, RESP_OKAY);
    axi_write(`MAE_COLLECTOR_OFS, 32'h1f, 4'hf, RESP_OKAY);
    axi_write(`MAE_COLLECTOR_OFS, 32'h0, 4'h3, RESP_OKAY);
    axi_read(`MAE_COLLECTOR_OFS, 32'h4, RESP_OKAY);
    clear_all();
    axi_read(`MAE_COLLECTOR_OFS, 32'h0, RESP_OKAY);
  endtask : t_scb

  task automatic t_async;
    src.async_pulse(1'b1);
    step(4);
    axi_read(`MAE_COLLECTOR_OFS, 32'h10, RESP_OKAY);
    src.async_pulse(1'b0);
    step(4);
    axi_read(`MAE_COLLECTOR_OFS, 32'h18, RESP_OKAY);
    clear_all();
  endtask : t_async

  task automatic t_mask;
    src.perif_access(1'b1, 1'b0);
    #1;
    `CHK("write abort", 1'b0, bus_abort)
    step(2);
    `CHK("irq", 1'b1, module_access_irq)
    axi_write(`MAE_IRQ_MASK_OFS, 32'h0, 4'hf, RESP_OKAY);
    #1;
    `CHK("irq masked", 1'b0, module_access_irq)
    axi_write(`MAE_IRQ_MASK_OFS, 32'h1f, 4'hf, RESP_OKAY);
    #1;
    `CHK("irq unmasked", 1'b1, module_access_irq)
    axi_write(`MAE_IRQ_STATUS_OFS, 32'h2, 4'hf, RESP_OKAY);
    #1;
    `CHK("irq cleared", 1'b0, module_access_irq)
    axi_read(`MAE_COLLECTOR_OFS, 32'h2, RESP_OKAY);
    clear_all();
  endtask : t_mask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_netc();
    t_perif();
    t_scb();
    t_async();
    t_mask();
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
